// file: design/crf_core.sv
// CPU register file top: two banks, shared pointers, program counter and the flag word.
// Assumes the execution datapath and interrupt acknowledge logic on the same clock drive it.
// Function
// RULE1 - Two banks of data, address and frame registers; one active at a time.
// RULE2 - Four 16-bit data registers; 0 and 1 split in bytes; pairs 0-2, 1-3.
// RULE3 - Two 16-bit address registers, usable for arithmetic, pair into 32 bits; the increment step adds to address 0 only.
// RULE4 - Frame base is 16 bits, base for frame-relative addressing.
// RULE5 - Vector table base is 20 bits holding the vector table start.
// RULE6 - Program counter is 20 bits holding the next instruction address.
// RULE7 - User and interrupt stack pointers are 16 bits; stack flag selects active.
// RULE8 - Static base is 16 bits for static-base-relative addressing.
// RULE9 - Flag word is 11 bits: eight flags plus priority level.
// RULE10 - Carry flag captures carry, borrow or shift-out of each producing operation.
// RULE11 - Controlling logic keeps the debug flag at zero.
// RULE12 - Zero flag is one for a zero result, else zero.
// RULE13 - Sign flag is one for a negative result, else zero.
// RULE14 - Bank flag zero selects bank zero, one selects bank one.
// RULE15 - Overflow flag is one on arithmetic overflow, else zero.
// RULE16 - Maskable interrupts blocked while enable flag is zero.
// RULE17 - Interrupt acknowledge clears the interrupt enable flag.
// RULE18 - Stack flag zero selects interrupt stack, one selects user stack.
// RULE19 - Hardware acknowledge or software interrupt 0 to 31 clears the stack flag.
// RULE20 - Priority level field is 3 bits, levels 0 through 7.
// RULE21 - Interrupt accepted only when its priority exceeds the processor level.
// RULE22 - Writers put zero in reserved flag bits; reads of them are undefined.
// RULE23 - Byte writes keep the other half; pair writes update both in one cycle.
// RULE24 - Equal priority is not accepted; it stays pending.
`default_nettype none
module crf_core #(
    parameter int W = crf_pkg::DATA_W,
    parameter int AW = crf_pkg::ADDR20_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Banked register write and read.
    input wire logic bank_wr_i,
    input wire crf_pkg::crf_bank_sel_t bank_wr_sel_i,
    input wire crf_pkg::crf_wsize_t bank_wr_size_i,
    input wire logic [2*W-1:0] bank_wr_data_i,
    input wire logic addr_inc_i,
    input wire logic [W-1:0] addr_inc_val_i,
    input wire crf_pkg::crf_bank_sel_t bank_rd_sel_i,
    output logic [2*W-1:0] bank_rd_data_o,
    // Shared register write and read.
    input wire logic shared_wr_i,
    input wire crf_pkg::crf_shared_sel_t shared_wr_sel_i,
    input wire logic [AW-1:0] shared_wr_data_i,
    input wire crf_pkg::crf_shared_sel_t shared_rd_sel_i,
    output logic [AW-1:0] shared_rd_data_o,
    input wire logic pc_load_i,
    input wire logic [AW-1:0] pc_next_i,
    // ALU result flags.
    input wire logic alu_carry_upd_i,
    input wire logic alu_carry_i,
    input wire logic alu_arith_upd_i,
    input wire logic [W-1:0] alu_result_i,
    input wire logic alu_ovfl_i,
    // Interrupt request and acknowledge.
    input wire logic irq_req_i,
    input wire logic [2:0] irq_prio_i,
    input wire logic irq_ack_i,
    input wire logic swint_i,
    input wire logic [5:0] swint_num_i,
    output logic irq_accept_o,
    // Direct state outputs.
    output logic [AW-1:0] pc_o,
    output logic [AW-1:0] vector_table_base_o,
    output logic [W-1:0] active_sp_o,
    output logic [W-1:0] static_base_o,
    output logic [W-1:0] frame_base_o,
    output logic [crf_pkg::FLAG_W-1:0] cpu_flag_word_o
);
    logic [W-1:0] bank0_regs [7];
    logic [W-1:0] bank1_regs [7];
    logic [W-1:0] act_regs [7];
    logic [AW-1:0] pc_reg;
    logic [AW-1:0] vtb_reg;
    logic [W-1:0] usp_reg;
    logic [W-1:0] isp_reg;
    logic [W-1:0] sb_reg;
    logic [crf_pkg::FLAG_W-1:0] flg_reg;
    logic bank_flag;
    logic stack_flag;
    logic ien_flag;
    logic [2:0] processor_priority_level;
    logic flg_wr;
    logic sp_wr;

    assign bank_flag = flg_reg[crf_pkg::FLG_BANK];
    assign stack_flag = flg_reg[crf_pkg::FLG_STACK];
    assign ien_flag = flg_reg[crf_pkg::FLG_IEN];
    assign processor_priority_level = flg_reg[crf_pkg::FLG_PRIO_LSB +: crf_pkg::PRIO_W]; // RULE20

    ////////////////////////////////////////////////////////////////////////////
    // Banks. Only the bank named by the bank flag takes writes.
    crf_bank #(.W(W)) u_bank0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(bank_wr_i && !bank_flag), // RULE1 RULE14
        .wr_sel_i(bank_wr_sel_i),
        .wr_size_i(bank_wr_size_i),
        .wr_data_i(bank_wr_data_i),
        .inc_en_i(addr_inc_i && !bank_flag),
        .inc_val_i(addr_inc_val_i),
        .regs_o(bank0_regs)
    );

    crf_bank #(.W(W)) u_bank1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(bank_wr_i && bank_flag), // RULE1 RULE14
        .wr_sel_i(bank_wr_sel_i),
        .wr_size_i(bank_wr_size_i),
        .wr_data_i(bank_wr_data_i),
        .inc_en_i(addr_inc_i && bank_flag),
        .inc_val_i(addr_inc_val_i),
        .regs_o(bank1_regs)
    );

    // Element by element copy of the bank that the bank flag picks.
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            act_regs[i] = bank_flag ? bank1_regs[i] : bank0_regs[i]; // RULE14
        end
    end

    // Read data comes from a flop; a 32-bit pair reads low register in the low half.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_rd_data_o <= '0;
        end else begin
            case (bank_rd_sel_i)
                crf_pkg::CRF_DATA0, crf_pkg::CRF_DATA2: begin
                    bank_rd_data_o <= {act_regs[2], act_regs[0]}; // RULE2
                end
                crf_pkg::CRF_DATA1, crf_pkg::CRF_DATA3: begin
                    bank_rd_data_o <= {act_regs[3], act_regs[1]};
                end
                crf_pkg::CRF_ADDR0, crf_pkg::CRF_ADDR1: begin
                    bank_rd_data_o <= {act_regs[5], act_regs[4]}; // RULE3
                end
                default: begin
                    bank_rd_data_o <= {{W{1'b0}}, act_regs[6]}; // RULE4
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared registers.
    assign sp_wr = shared_wr_i && shared_wr_sel_i == crf_pkg::CRF_SP;
    assign flg_wr = shared_wr_i && shared_wr_sel_i == crf_pkg::CRF_FLG;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_reg <= crf_pkg::REG20_RESET;
        end else if (pc_load_i) begin
            pc_reg <= pc_next_i; // RULE6
        end else if (shared_wr_i && shared_wr_sel_i == crf_pkg::CRF_PC) begin
            pc_reg <= shared_wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vtb_reg <= crf_pkg::REG20_RESET;
            sb_reg <= crf_pkg::REG16_RESET;
        end else if (shared_wr_i) begin
            if (shared_wr_sel_i == crf_pkg::CRF_VTB) begin
                vtb_reg <= shared_wr_data_i; // RULE5
            end
            if (shared_wr_sel_i == crf_pkg::CRF_SB) begin
                sb_reg <= shared_wr_data_i[W-1:0]; // RULE8
            end
        end
    end

    // The active-pointer alias writes whichever pointer the stack flag picks.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            usp_reg <= crf_pkg::REG16_RESET;
            isp_reg <= crf_pkg::REG16_RESET;
        end else if (shared_wr_i) begin
            if (shared_wr_sel_i == crf_pkg::CRF_USP || (sp_wr && stack_flag)) begin
                usp_reg <= shared_wr_data_i[W-1:0]; // RULE7
            end
            if (shared_wr_sel_i == crf_pkg::CRF_ISP || (sp_wr && !stack_flag)) begin
                isp_reg <= shared_wr_data_i[W-1:0]; // RULE7
            end
        end
    end

    assign active_sp_o = stack_flag ? usp_reg : isp_reg; // RULE7 RULE18

    ////////////////////////////////////////////////////////////////////////////
    // Flag word. Hardware events override a same-cycle software write of the same bits.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flg_reg <= crf_pkg::FLG_RESET[crf_pkg::FLAG_W-1:0];
        end else begin
            if (flg_wr) begin
                // Reserved bits above the word are dropped, so they never hold state.
                flg_reg <= shared_wr_data_i[crf_pkg::FLAG_W-1:0]; // RULE9 RULE22
            end
            if (alu_carry_upd_i) begin
                flg_reg[crf_pkg::FLG_CARRY] <= alu_carry_i; // RULE10
            end
            if (alu_arith_upd_i) begin
                flg_reg[crf_pkg::FLG_ZERO] <= alu_result_i == '0; // RULE12
                flg_reg[crf_pkg::FLG_SIGN] <= alu_result_i[W-1]; // RULE13
                flg_reg[crf_pkg::FLG_OVFL] <= alu_ovfl_i; // RULE15
            end
            if (irq_ack_i) begin
                flg_reg[crf_pkg::FLG_IEN] <= 1'b0; // RULE17
                flg_reg[crf_pkg::FLG_STACK] <= 1'b0; // RULE19
            end
            if (swint_i && swint_num_i <= {1'b0, crf_pkg::SWINT_CLR_MAX}) begin
                flg_reg[crf_pkg::FLG_STACK] <= 1'b0; // RULE19
            end
        end
    end

    // Accept only enabled requests strictly above the current level; equal stays pending.
    assign irq_accept_o = irq_req_i && ien_flag && (irq_prio_i > processor_priority_level); // RULE16 RULE21 RULE24

    ////////////////////////////////////////////////////////////////////////////
    // Shared read port, registered.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shared_rd_data_o <= '0;
        end else begin
            case (shared_rd_sel_i)
                crf_pkg::CRF_VTB: shared_rd_data_o <= vtb_reg;
                crf_pkg::CRF_PC: shared_rd_data_o <= pc_reg;
                crf_pkg::CRF_USP: shared_rd_data_o <= {4'h0, usp_reg};
                crf_pkg::CRF_ISP: shared_rd_data_o <= {4'h0, isp_reg};
                crf_pkg::CRF_SB: shared_rd_data_o <= {4'h0, sb_reg};
                crf_pkg::CRF_FLG: shared_rd_data_o <= {9'h000, flg_reg}; // RULE22
                default: shared_rd_data_o <= {4'h0, active_sp_o};
            endcase
        end
    end

    assign pc_o = pc_reg;
    assign vector_table_base_o = vtb_reg;
    assign static_base_o = sb_reg;
    assign frame_base_o = act_regs[6]; // RULE4
    assign cpu_flag_word_o = flg_reg;

    ////////////////////////////////////////////////////////////////////////////
    chk_ack_clears_flags: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
        irq_ack_i |=> !ien_flag && !stack_flag)
        else $error("acknowledge did not clear enable and stack flags");

    chk_swint_stack_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19
        swint_i && swint_num_i < 6'h20 |=> !stack_flag)
        else $error("software interrupt below 32 did not clear stack flag");

    chk_equal_prio_pending: assert property (@(posedge clk_i) disable iff (rst_i) // RULE24
        irq_prio_i == processor_priority_level |-> !irq_accept_o)
        else $error("equal priority request was accepted");

    chk_accept_needs_ien: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
        irq_accept_o |-> ien_flag && irq_prio_i > processor_priority_level)
        else $error("interrupt accepted while blocked");

    chk_zero_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
        alu_arith_upd_i && !irq_ack_i |=> flg_reg[crf_pkg::FLG_ZERO] == ($past(alu_result_i) == '0))
        else $error("zero flag does not match result");

    chk_sign_ovfl: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        alu_arith_upd_i |=> flg_reg[crf_pkg::FLG_SIGN] == $past(alu_result_i[W-1])
            && flg_reg[crf_pkg::FLG_OVFL] == $past(alu_ovfl_i))
        else $error("sign or overflow flag wrong");

    chk_carry_capture: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        alu_carry_upd_i |=> flg_reg[crf_pkg::FLG_CARRY] == $past(alu_carry_i))
        else $error("carry flag not captured");

    chk_active_sp_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
        active_sp_o == (flg_reg[crf_pkg::FLG_STACK] ? usp_reg : isp_reg))
        else $error("active stack pointer wrong");

    chk_pc_load: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        pc_load_i |=> pc_o == $past(pc_next_i))
        else $error("program counter did not load");

    chk_bank_isolation: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        bank_wr_i && !bank_flag && !addr_inc_i |=> $stable(bank1_regs[0]))
        else $error("inactive bank changed on write");

    // A write through the pointer alias must show on the active pointer output one cycle later.
    chk_sp_alias_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        shared_wr_i && shared_wr_sel_i == crf_pkg::CRF_SP && !irq_ack_i && !swint_i
        |=> active_sp_o == $past(shared_wr_data_i[W-1:0]))
        else $error("write through the active pointer alias was lost");
    chk_bank0_isolation: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        bank_wr_i && bank_flag && !addr_inc_i |=> $stable(bank0_regs[0]))
        else $error("inactive bank zero changed on write");
    chk_byte_half_kept: assert property (@(posedge clk_i) disable iff (rst_i) // RULE23
        bank_wr_i && !bank_flag && bank_wr_size_i == crf_pkg::CRF_W8LO && bank_wr_sel_i == crf_pkg::CRF_DATA0
        |=> $stable(bank0_regs[0][W-1:W/2]))
        else $error("byte write disturbed the other half");
    chk_pair_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE23
        bank_wr_i && !bank_flag && bank_wr_size_i == crf_pkg::CRF_W32 && bank_wr_sel_i == crf_pkg::CRF_DATA0
        |=> bank0_regs[0] == $past(bank_wr_data_i[W-1:0]) && bank0_regs[2] == $past(bank_wr_data_i[2*W-1:W]))
        else $error("pair write did not load both registers");
    chk_flag_read_reserved: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
        shared_rd_sel_i == crf_pkg::CRF_FLG |=> shared_rd_data_o[AW-1:crf_pkg::FLAG_W] == '0)
        else $error("reserved flag bits read back nonzero");
    chk_swint_high_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19
        swint_i && swint_num_i > 6'h1f && !irq_ack_i && !flg_wr |=> $stable(stack_flag))
        else $error("software interrupt above 31 changed the stack flag");
endmodule
`default_nettype wire

// file: design/crf_pkg.sv
// Package for the CPU register file: selectors, flag word layout, widths and reset values.
// Assumes nothing of its surroundings; every design file refers to it by scoped name.
`default_nettype none
package crf_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR20_W = 20;
    localparam int FLAG_W = 11;
    localparam int PRIO_W = 3;
    // Flag word bit positions.
    localparam int FLG_CARRY = 0;
    localparam int FLG_DEBUG = 1;
    localparam int FLG_ZERO = 2;
    localparam int FLG_SIGN = 3;
    localparam int FLG_BANK = 4;
    localparam int FLG_OVFL = 5;
    localparam int FLG_IEN = 6;
    localparam int FLG_STACK = 7;
    localparam int FLG_PRIO_LSB = 8;
    // Bits that hold state; the rest of the 16-bit word is reserved.
    localparam logic [15:0] FLG_IMPL_MASK = 16'h07ff;
    localparam logic [15:0] FLG_RESET = 16'h0000;
    localparam logic [15:0] REG16_RESET = 16'h0000;
    localparam logic [19:0] REG20_RESET = 20'h00000;
    localparam logic [4:0] SWINT_CLR_MAX = 5'h1f;
    // Banked register selector.
    typedef enum logic [2:0] {
        CRF_DATA0, CRF_DATA1, CRF_DATA2, CRF_DATA3, CRF_ADDR0, CRF_ADDR1, CRF_FRAME
    } crf_bank_sel_t;
    // Write width for a banked write.
    typedef enum logic [2:0] {
        CRF_W16, CRF_W8LO, CRF_W8HI, CRF_W32
    } crf_wsize_t;
    // Shared register selector.
    typedef enum logic [2:0] {
        CRF_VTB, CRF_PC, CRF_USP, CRF_ISP, CRF_SB, CRF_FLG, CRF_SP
    } crf_shared_sel_t;
endpackage
`default_nettype wire

// file: design/crf_bank.sv
// One register bank: four data registers, two address registers and a frame base.
// Assumes the parent decodes bank selection and only asserts write enable for the active bank.
`default_nettype none
module crf_bank #(
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire crf_pkg::crf_bank_sel_t wr_sel_i,
    input wire crf_pkg::crf_wsize_t wr_size_i,
    input wire logic [2*W-1:0] wr_data_i,
    input wire logic inc_en_i,
    input wire logic [W-1:0] inc_val_i,
    output logic [W-1:0] regs_o [7]
);
    logic [W-1:0] regs_reg [7];

    ////////////////////////////////////////////////////////////////////////////
    // Byte writes keep the other half; 32-bit writes load both halves of a pair at once.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 7; i++) begin
                regs_reg[i] <= crf_pkg::REG16_RESET;
            end
        end else if (wr_en_i) begin
            case (wr_size_i)
                crf_pkg::CRF_W8LO: begin
                    regs_reg[wr_sel_i][W/2-1:0] <= wr_data_i[W/2-1:0]; // RULE2 RULE23
                end
                crf_pkg::CRF_W8HI: begin
                    regs_reg[wr_sel_i][W-1:W/2] <= wr_data_i[W/2-1:0]; // RULE23
                end
                crf_pkg::CRF_W32: begin
                    // Pairs: data 0 with 2, data 1 with 3, address 0 with 1.
                    case (wr_sel_i)
                        crf_pkg::CRF_DATA0, crf_pkg::CRF_DATA2: begin
                            regs_reg[0] <= wr_data_i[W-1:0]; // RULE2 RULE23
                            regs_reg[2] <= wr_data_i[2*W-1:W];
                        end
                        crf_pkg::CRF_DATA1, crf_pkg::CRF_DATA3: begin
                            regs_reg[1] <= wr_data_i[W-1:0];
                            regs_reg[3] <= wr_data_i[2*W-1:W];
                        end
                        crf_pkg::CRF_ADDR0, crf_pkg::CRF_ADDR1: begin
                            regs_reg[4] <= wr_data_i[W-1:0]; // RULE3
                            regs_reg[5] <= wr_data_i[2*W-1:W];
                        end
                        default: begin
                            regs_reg[wr_sel_i] <= wr_data_i[W-1:0];
                        end
                    endcase
                end
                default: begin
                    regs_reg[wr_sel_i] <= wr_data_i[W-1:0];
                end
            endcase
        end else if (inc_en_i) begin
            // Address register 0 arithmetic adds a signed step without a full write.
            regs_reg[4] <= regs_reg[4] + inc_val_i; // RULE3
        end
    end

    assign regs_o = regs_reg;
endmodule
`default_nettype wire

// file: test/crf_ack_model.sv
// Interrupt acknowledge responder standing where the core's acknowledge logic would be.
// Assumes the bench clock and a level request that is held until it is acknowledged.
`default_nettype none
module crf_ack_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic accept_i,
    input wire logic [3:0] lat_i,
    output logic ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_reg = 4'h0;
    // The wait lets the bench try both a prompt and a slow acknowledge.
    always @(negedge clk_i) begin
        if (rst_i || !en_i || ack_o || !accept_i) begin
            wait_reg <= 4'h0;
            ack_o <= 1'h0;
        end else if (wait_reg >= lat_i) begin
            ack_o <= 1'h1;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule
`default_nettype wire

// file: test/crf_core_tb_top.sv
// Self-checking bench for the register file, with the acknowledge model on the interrupt side.
// Assumes the design package is compiled first; inputs change on the falling clock edge.
`default_nettype none
module crf_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'h0, rst_i = 1'h1, bank_wr_i = 1'h0, addr_inc_i = 1'h0, shared_wr_i = 1'h0;
    logic pc_load_i = 1'h0, alu_carry_upd_i = 1'h0, alu_carry_i = 1'h0, alu_arith_upd_i = 1'h0;
    logic alu_ovfl_i = 1'h0, irq_req_i = 1'h0, irq_ack_i, swint_i = 1'h0, irq_accept_o, ack_en = 1'h0;
    crf_pkg::crf_bank_sel_t bank_wr_sel_i = crf_pkg::CRF_DATA0, bank_rd_sel_i = crf_pkg::CRF_DATA0;
    crf_pkg::crf_wsize_t bank_wr_size_i = crf_pkg::CRF_W16;
    crf_pkg::crf_shared_sel_t shared_wr_sel_i = crf_pkg::CRF_VTB, shared_rd_sel_i = crf_pkg::CRF_VTB;
    logic [31:0] bank_wr_data_i = 32'h0, bank_rd_data_o;
    logic [19:0] shared_wr_data_i = 20'h0, pc_next_i = 20'h0, shared_rd_data_o, pc_o, vector_table_base_o;
    logic [15:0] addr_inc_val_i = 16'h0, alu_result_i = 16'h0, active_sp_o, static_base_o, frame_base_o;
    logic [2:0] irq_prio_i = 3'h0;
    logic [5:0] swint_num_i = 6'h0;
    logic [10:0] cpu_flag_word_o;
    logic [3:0] ack_lat = 4'h0;
    int num_errors = 0;
    int compares = 0;
    always #2.5 clk_i = ~clk_i;
    crf_core u_dut (.clk_i, .rst_i, .bank_wr_i, .bank_wr_sel_i, .bank_wr_size_i, .bank_wr_data_i,
        .addr_inc_i, .addr_inc_val_i, .bank_rd_sel_i, .bank_rd_data_o, .shared_wr_i, .shared_wr_sel_i,
        .shared_wr_data_i, .shared_rd_sel_i, .shared_rd_data_o, .pc_load_i, .pc_next_i, .alu_carry_upd_i,
        .alu_carry_i, .alu_arith_upd_i, .alu_result_i, .alu_ovfl_i, .irq_req_i, .irq_prio_i, .irq_ack_i,
        .swint_i, .swint_num_i, .irq_accept_o, .pc_o, .vector_table_base_o, .active_sp_o, .static_base_o,
        .frame_base_o, .cpu_flag_word_o);
    crf_ack_model u_ack (.clk_i, .rst_i, .en_i(ack_en), .accept_i(irq_accept_o), .lat_i(ack_lat),
        .ack_o(irq_ack_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bwr(input crf_pkg::crf_bank_sel_t s, input crf_pkg::crf_wsize_t z, input logic [31:0] d);
        @(negedge clk_i);
        bank_wr_i = 1'h1;
        bank_wr_sel_i = s;
        bank_wr_size_i = z;
        bank_wr_data_i = d;
        @(negedge clk_i);
        bank_wr_i = 1'h0;
    endtask
    task automatic brd(input crf_pkg::crf_bank_sel_t s, input logic [31:0] e);
        @(negedge clk_i);
        bank_rd_sel_i = s;
        @(negedge clk_i);
        check(bank_rd_data_o, e);
    endtask
    task automatic inc(input logic [15:0] v);
        @(negedge clk_i);
        addr_inc_i = 1'h1;
        addr_inc_val_i = v;
        @(negedge clk_i);
        addr_inc_i = 1'h0;
    endtask
    task automatic swr(input crf_pkg::crf_shared_sel_t s, input logic [19:0] d);
        @(negedge clk_i);
        shared_wr_i = 1'h1;
        shared_wr_sel_i = s;
        shared_wr_data_i = (s == crf_pkg::CRF_FLG) ? (d & 20'h007fd) : d;
        @(negedge clk_i);
        shared_wr_i = 1'h0;
    endtask
    task automatic srd(input crf_pkg::crf_shared_sel_t s, input logic [19:0] e);
        @(negedge clk_i);
        shared_rd_sel_i = s;
        @(negedge clk_i);
        check(shared_rd_data_o, e);
    endtask
    task automatic alu(input logic cu, c, au, input logic [15:0] r, input logic o, input logic [10:0] e);
        @(negedge clk_i);
        {alu_carry_upd_i, alu_carry_i, alu_arith_upd_i, alu_result_i, alu_ovfl_i} = {cu, c, au, r, o};
        @(negedge clk_i);
        alu_carry_upd_i = 1'h0;
        alu_arith_upd_i = 1'h0;
        check(cpu_flag_word_o, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // The whole sequence needs about two hundred cycles; the limit leaves ample margin.
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
    initial begin
        int n;
        int nums [4] = '{0, 31, 32, 63};
        int lats [2] = '{0, 4};
        repeat (5) @(negedge clk_i);
        rst_i = 1'h0;
        check({irq_accept_o, pc_o, cpu_flag_word_o}, 32'h0);
        bwr(crf_pkg::CRF_DATA0, crf_pkg::CRF_W32, 32'h12345678);
        brd(crf_pkg::CRF_DATA0, 32'h12345678);
        bwr(crf_pkg::CRF_DATA0, crf_pkg::CRF_W8LO, 32'h000000ab);
        brd(crf_pkg::CRF_DATA2, 32'h123456ab);
        bwr(crf_pkg::CRF_DATA1, crf_pkg::CRF_W32, 32'haaaa5555);
        bwr(crf_pkg::CRF_DATA1, crf_pkg::CRF_W8HI, 32'h00000077);
        brd(crf_pkg::CRF_DATA3, 32'haaaa7755);
        bwr(crf_pkg::CRF_ADDR0, crf_pkg::CRF_W32, 32'hbeef1234);
        inc(16'h0010);
        brd(crf_pkg::CRF_ADDR1, 32'hbeef1244);
        inc(16'hffff);
        brd(crf_pkg::CRF_ADDR0, 32'hbeef1243);
        bwr(crf_pkg::CRF_FRAME, crf_pkg::CRF_W16, 32'h000000c3);
        check(frame_base_o, 32'h00c3);
        brd(crf_pkg::CRF_FRAME, 32'h000000c3);
        swr(crf_pkg::CRF_FLG, 20'h00010);
        check(frame_base_o, 32'h0);
        bwr(crf_pkg::CRF_DATA0, crf_pkg::CRF_W32, 32'h11112222);
        swr(crf_pkg::CRF_FLG, 20'h0);
        brd(crf_pkg::CRF_DATA0, 32'h123456ab);
        swr(crf_pkg::CRF_FLG, 20'h00010);
        brd(crf_pkg::CRF_DATA0, 32'h11112222);
        swr(crf_pkg::CRF_VTB, 20'habcde);
        srd(crf_pkg::CRF_VTB, 20'habcde);
        swr(crf_pkg::CRF_SB, 20'h04321);
        srd(crf_pkg::CRF_SB, 20'h04321);
        check({vector_table_base_o, static_base_o[11:0]}, 32'habcde321);
        @(negedge clk_i);
        pc_load_i = 1'h1;
        pc_next_i = 20'h12345;
        @(negedge clk_i);
        pc_load_i = 1'h0;
        check(pc_o, 32'h12345);
        swr(crf_pkg::CRF_ISP, 20'h01000);
        swr(crf_pkg::CRF_USP, 20'h02000);
        check(active_sp_o, 32'h1000);
        foreach (nums[i]) begin
            swr(crf_pkg::CRF_FLG, 20'h00080);
            check(active_sp_o, 32'h2000);
            @(negedge clk_i);
            swint_i = 1'h1;
            swint_num_i = nums[i][5:0];
            @(negedge clk_i);
            swint_i = 1'h0;
            check(active_sp_o, (nums[i] <= 31) ? 32'h1000 : 32'h2000);
        end
        swr(crf_pkg::CRF_SP, 20'h02200);
        srd(crf_pkg::CRF_SP, 20'h02200);
        srd(crf_pkg::CRF_USP, 20'h02200);
        srd(crf_pkg::CRF_ISP, 20'h01000);
        swr(crf_pkg::CRF_PC, 20'h54321);
        srd(crf_pkg::CRF_PC, 20'h54321);
        swr(crf_pkg::CRF_FLG, 20'hfff82);
        srd(crf_pkg::CRF_FLG, 20'h00780);
        swr(crf_pkg::CRF_FLG, 20'h0);
        alu(1'h1, 1'h1, 1'h0, 16'h0, 1'h0, 11'h001);
        alu(1'h0, 1'h0, 1'h1, 16'h0000, 1'h0, 11'h005);
        alu(1'h0, 1'h0, 1'h1, 16'h8000, 1'h1, 11'h029);
        alu(1'h1, 1'h0, 1'h1, 16'h0001, 1'h0, 11'h000);
        for (int l = 0; l < 8; l++) begin
            swr(crf_pkg::CRF_FLG, {9'h0, l[2:0], 8'h40});
            for (int p = 0; p < 8; p++) begin
                @(negedge clk_i);
                irq_req_i = 1'h1;
                irq_prio_i = p[2:0];
                #1 check(irq_accept_o, p > l);
            end
        end
        swr(crf_pkg::CRF_FLG, 20'h0);
        check(irq_accept_o, 32'h0);
        foreach (lats[i]) begin
            irq_req_i = 1'h0;
            swr(crf_pkg::CRF_FLG, 20'h002c0);
            irq_prio_i = 3'h5;
            irq_req_i = 1'h1;
            ack_lat = lats[i][3:0];
            ack_en = 1'h1;
            n = 0;
            while (irq_ack_i !== 1'h1 && n < 12) begin
                @(posedge clk_i);
                n++;
            end
            check(n < 12, 32'h1);
            @(negedge clk_i);
            check(cpu_flag_word_o, 32'h200);
            check(irq_accept_o, 32'h0);
            check(active_sp_o, 32'h1000);
            ack_en = 1'h0;
        end
        irq_req_i = 1'h0;
        wrap_up();
    end
endmodule
`default_nettype wire
